// ---- dv/host_model.sv ----
/*
  Host model driving the register port and refresh strobe.
  Assumes inputs are taken at the rising edge; drives at falling edges.
*/
`timescale 1ns/1ps
module host_model #(
  parameter int VALID_DELAY = 8
) (
  input wire logic sys_clk_i,
  output logic refresh_o,
  output logic [15:0] staged_o,
  output logic [15:0] control_o,
  output logic [7:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [15:0] wdata_o,
  input wire logic [15:0] rdata_i
);
  initial begin
    {refresh_o, rd_o, wr_o, addr_o} = 11'h0;
    {staged_o, control_o, wdata_o} = 48'h0;
  end
  task automatic write(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk_i);
    {addr_o, wdata_o, wr_o} = {a, d, 1'h1};
    @(negedge sys_clk_i);
    {wdata_o, wr_o} = {~d, 1'h0};
  endtask : write
  task automatic read(input logic [7:0] a, output logic [15:0] d);
    @(negedge sys_clk_i);
    {addr_o, rd_o} = {a, 1'h1};
    @(negedge sys_clk_i);
    rd_o = 1'h0;
    d = rdata_i;
  endtask : read
  task automatic refresh(input logic [15:0] s, input logic [15:0] c);
    @(negedge sys_clk_i);
    {staged_o, control_o, refresh_o} = {s, c, 1'h1};
    @(negedge sys_clk_i);
    refresh_o = 1'h0;
  endtask : refresh
  task automatic wait_valid();
    repeat (VALID_DELAY) @(negedge sys_clk_i);
  endtask : wait_valid
endmodule : host_model

// ---- dv/readback_asserts.sv ----
/*
  Concurrent checks on the readback block ports.
  Assumes binding into the top module, one clock, synchronous reset.
*/
`timescale 1ns/1ps
module readback_asserts
  import readback_pkg::*;
#(
  parameter int VALID_DELAY = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic refresh_i,
  input wire logic [15:0] staged_range_i,
  input wire logic [15:0] active_control_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_hit_o,
  input wire logic readback_valid_o,
  input wire logic latched_valid_o,
  input wire logic [1:0] sense_range_ch1_o,
  input wire logic [1:0] sense_range_ch2_o,
  input wire logic [1:0] sense_range_ch3_o,
  input wire logic [1:0] sense_range_ch4_o,
  input wire logic [1:0] bus_range_ch1_o,
  input wire logic [1:0] bus_range_ch2_o,
  input wire logic [1:0] bus_range_ch3_o,
  input wire logic [1:0] bus_range_ch4_o,
  input wire logic [1:0] range_reserved_o,
  input readback_pkg::mode_class_t latched_mode_class_o,
  input wire logic [1:0] pin2_function_select_o,
  input wire logic [1:0] pin1_function_select_o,
  input wire logic [3:0] channel_off_o
);
  logic [15:0] act;
  logic [7:0] lat;
  logic seen;
  logic [31:0] cnt;
  assign act = {sense_range_ch1_o, sense_range_ch2_o, sense_range_ch3_o,
    sense_range_ch4_o, bus_range_ch1_o, bus_range_ch2_o, bus_range_ch3_o,
    bus_range_ch4_o};
  assign lat = {pin2_function_select_o, pin1_function_select_o,
    channel_off_o};
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i || refresh_i) begin
      cnt <= 32'h0;
    end else if (cnt < VALID_DELAY) begin
      cnt <= cnt + 32'h1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      seen <= 1'h0;
    end else if (refresh_i) begin
      seen <= 1'h1;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_range_hold: assert property (
    !refresh_i && !reg_wr_i |=> $stable(act))
    else $error("active ranges moved without refresh");
  a_refresh_load: assert property (
    refresh_i |=> act == $past(staged_range_i))
    else $error("refresh did not load staged ranges");
  a_write_load: assert property (
    reg_wr_i && !refresh_i && reg_addr_i == 8'h22
    |=> act == $past(reg_wdata_i))
    else $error("host write did not load active ranges");
  a_read_active: assert property (
    reg_rd_i && !reg_wr_i && !refresh_i && reg_addr_i == 8'h22
    |=> reg_rdata_o == act)
    else $error("active range read mismatch");
  a_hit_decode: assert property (
    reg_hit_o == (reg_addr_i == 8'h22 || reg_addr_i == 8'h23))
    else $error("register hit decode wrong");
  a_reserved_flag: assert property (
    range_reserved_o ==
    {(&act[15:14]) | (&act[13:12]) | (&act[11:10]) | (&act[9:8]),
     (&act[7:6]) | (&act[5:4]) | (&act[3:2]) | (&act[1:0])})
    else $error("reserved range flag wrong");
  a_valid_timer: assert property (
    readback_valid_o == (seen && cnt >= VALID_DELAY))
    else $error("valid timing wrong");
  a_latch_invalid: assert property (
    !seen |-> !latched_valid_o)
    else $error("latched valid before first refresh");
  a_latch_ctrl: assert property (
    refresh_i |=> lat == $past(active_control_i[11:4]))
    else $error("latched control not captured");
  a_mode_sleep: assert property (
    refresh_i && active_control_i[15:12] == MODE_SLEEP
    |=> latched_mode_class_o == SEL_SLEEP)
    else $error("sleep mode not decoded");
  a_ro_write: assert property (
    reg_wr_i && !refresh_i && reg_addr_i == 8'h23
    |=> $stable(lat) && $stable(latched_mode_class_o))
    else $error("latched control changed by write");
endmodule : readback_asserts

// ---- dv/testbench.sv ----
/*
  Self-checking bench for the readback block.
  Assumes the host model drives all block inputs except clock and reset.
*/
`timescale 1ns/1ps
module testbench;
  import readback_pkg::*;
  localparam int VALID_DELAY = 8;
  logic sys_clk = 1'h0, rst_b = 1'h0, ref_s, rd, wr, hit, rv, lv;
  logic [15:0] stg, ctl, wd, rdat, d;
  logic [7:0] ad;
  logic [1:0] s1, s2, s3, s4, b1, b2, b3, b4, rsv, p2, p1;
  logic [3:0] off;
  mode_class_t mc;
  int failures = 0, checked = 0;
  always #2 sys_clk = ~sys_clk;
  host_model #(.VALID_DELAY(VALID_DELAY)) host (.sys_clk_i(sys_clk),
    .refresh_o(ref_s), .staged_o(stg), .control_o(ctl), .addr_o(ad),
    .rd_o(rd), .wr_o(wr), .wdata_o(wd), .rdata_i(rdat));
  active_latched_config_readback #(.VALID_DELAY(VALID_DELAY)) uut (
    .sys_clk_i(sys_clk), .rst_b_i(rst_b), .refresh_i(ref_s),
    .staged_range_i(stg), .active_control_i(ctl), .reg_addr_i(ad),
    .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .reg_hit_o(hit), .readback_valid_o(rv), .latched_valid_o(lv),
    .sense_range_ch1_o(s1), .sense_range_ch2_o(s2), .sense_range_ch3_o(s3),
    .sense_range_ch4_o(s4), .bus_range_ch1_o(b1), .bus_range_ch2_o(b2),
    .bus_range_ch3_o(b3), .bus_range_ch4_o(b4), .range_reserved_o(rsv),
    .latched_mode_class_o(mc), .pin2_function_select_o(p2),
    .pin1_function_select_o(p1), .channel_off_o(off));
  task automatic check(input string what, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic mode_class_t cls(input logic [3:0] m);
    return m < 4'h4 ? SEL_CONTINUOUS_ADAPTIVE : m < 4'h8 ? SEL_CONTINUOUS :
      m == MODE_SINGLE_SHOT ? SEL_SINGLE_SHOT : m == MODE_SINGLE_SHOT_8X ?
      SEL_SINGLE_SHOT_8X : m == MODE_FAST ? SEL_FAST : m == MODE_BURST ?
      SEL_BURST : m == MODE_SLEEP ? SEL_SLEEP : SEL_RESERVED;
  endfunction : cls
  task automatic end_sim();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  initial begin
    #20000 failures++;
    end_sim();
  end
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_b = 1'h1;
    host.read(8'h22, d);
    check("active", d, 16'h0000);
    check("hit", {15'h0, hit}, 16'h1);
    check("valid", {15'h0, rv}, 16'h0);
    check("latched valid", {15'h0, lv}, 16'h0);
    host.staged_o = 16'h1B93;
    host.read(8'h22, d);
    check("staged hidden", d, 16'h0000);
    $display("test reset done");
    host.refresh(16'h1B93, 16'hF7AB);
    check("valid drop", {15'h0, rv}, 16'h0);
    host.wait_valid();
    check("valid up", {14'h0, rv, lv}, 16'h3);
    host.read(8'h22, d);
    check("active", d, 16'h1B93);
    check("sense", {8'h0, s1, s2, s3, s4}, 16'h001B);
    check("bus", {8'h0, b1, b2, b3, b4}, 16'h0093);
    check("reserved", {14'h0, rsv}, 16'h3);
    host.read(8'h23, d);
    check("latched", d, 16'hF7A0);
    check("pins", {8'h0, p2, p1, off}, 16'h007A);
    check("mode", {13'h0, mc}, {13'h0, SEL_SLEEP});
    host.write(8'h23, 16'hFFFF);
    host.read(8'h23, d);
    check("latched ro", d, 16'hF7A0);
    host.read(8'h30, d);
    check("unmapped", d, 16'h0000);
    check("no hit", {15'h0, hit}, 16'h0);
    host.write(8'h22, 16'h4C63);
    host.read(8'h22, d);
    check("written", d, 16'h4C63);
    check("sense", {8'h0, s1, s2, s3, s4}, 16'h004C);
    $display("test refresh done");
    host.refresh(16'h2A52, 16'h8123);
    check("valid drop", {15'h0, rv}, 16'h0);
    host.wait_valid();
    check("valid up", {14'h0, rv, lv}, 16'h3);
    host.read(8'h23, d);
    check("latched", d, 16'h8120);
    host.read(8'h22, d);
    check("active", d, 16'h2A52);
    check("reserved", {14'h0, rsv}, 16'h0);
    for (int i = 0; i < 16; i++) begin
      host.refresh(16'h0000, {i[3:0], 12'h700});
      check("mode", {13'h0, mc}, {13'h0, cls(i[3:0])});
    end
    $display("test modes done");
    end_sim();
  end
endmodule : testbench
bind active_latched_config_readback readback_asserts #(
  .VALID_DELAY(VALID_DELAY)) chk (.*);

// ---- rtl/active_latched_config_readback.sv ----
/*
  Readback copies of the power monitor configuration: the active range
  register and the latched control register, with the valid timer that
  follows each refresh.
  Assumes the register port is driven by the management bus engine and
  that the refresh strobe is one cycle long for every refresh variant.
*/
// How it works
// RULE1 - Active ranges change only on refresh. A host write to ACTIVE_RANGE_OFFSET (8'h22) also loads them here.
// RULE2 - Copies valid 1 ms after any refresh.
// RULE3 - Sense range codes: unipolar, 100, 50, reserved.
// RULE4 - Sense fields at bits 15-8, channel one high.
// RULE5 - Bus range codes: unipolar, 9V, 4.5V, reserved.
// RULE6 - Bus fields at bits 7-0, channel one high.
// RULE7 - Every refresh latches control settings before it.
// RULE8 - Latched control invalid until first refresh.
// RULE9 - Latched control is read-only control image.
// RULE10 - Sampling mode decodes to exactly one mode.
// RULE11 - Writes to latched control change nothing.
`timescale 1ns/1ps
module active_latched_config_readback
  import readback_pkg::*;
#(
  parameter int VALID_DELAY = VALID_DELAY_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic refresh_i,
  input wire logic [15:0] staged_range_i,
  input wire logic [15:0] active_control_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_hit_o,
  output logic readback_valid_o,
  output logic latched_valid_o,
  output logic [1:0] sense_range_ch1_o,
  output logic [1:0] sense_range_ch2_o,
  output logic [1:0] sense_range_ch3_o,
  output logic [1:0] sense_range_ch4_o,
  output logic [1:0] bus_range_ch1_o,
  output logic [1:0] bus_range_ch2_o,
  output logic [1:0] bus_range_ch3_o,
  output logic [1:0] bus_range_ch4_o,
  output logic [1:0] range_reserved_o,
  output readback_pkg::mode_class_t latched_mode_class_o,
  output logic [1:0] pin2_function_select_o,
  output logic [1:0] pin1_function_select_o,
  output logic [3:0] channel_off_o
);
  import readback_pkg::*;

  typedef enum logic [1:0] {
    TIMER_IDLE,
    TIMER_WAIT,
    TIMER_DONE
  } timer_state_t;

  localparam int CNT_W = $clog2(VALID_DELAY + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(VALID_DELAY - 1);

  timer_state_t state;
  logic [CNT_W-1:0] count;
  logic seen_refresh;
  logic wr_active;
  logic [15:0] active_range;
  logic [15:0] latched_control;
  logic [3:0] mode;
  logic [15:0] next_rdata;

  capture_if #(.WIDTH(16)) range_cap ();
  capture_if #(.WIDTH(16)) control_cap ();

  // ----------------------------------------------------------------------
  // Capture registers
  // ----------------------------------------------------------------------
  assign wr_active = reg_wr_i && (reg_addr_i == ACTIVE_RANGE_OFFSET);
  // A refresh outranks a host write in the same cycle.
  assign range_cap.load = refresh_i || wr_active; // RULE1
  assign range_cap.data = refresh_i ? staged_range_i : reg_wdata_i; // RULE1
  assign active_range = range_cap.image;

  // Only a refresh loads the image; the write strobe never reaches it.
  assign control_cap.load = refresh_i; // RULE7 RULE11
  assign control_cap.data = active_control_i & LATCHED_CONTROL_MASK; // RULE9
  assign latched_control = control_cap.image;

  capture_reg #(
    .WIDTH(16),
    .RESET_VALUE(ACTIVE_RANGE_RESET)
  ) u_range_reg (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .cap(range_cap.owner)
  );

  capture_reg #(
    .WIDTH(16),
    .RESET_VALUE(LATCHED_CONTROL_RESET)
  ) u_control_reg (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .cap(control_cap.owner)
  );

  // ----------------------------------------------------------------------
  // Valid timer
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state <= TIMER_IDLE;
      count <= '0;
    end else if (refresh_i) begin
      state <= TIMER_WAIT; // RULE2
      count <= '0;
    end else begin
      case (state)
        TIMER_WAIT: begin
          if (count == CNT_LAST) begin
            state <= TIMER_DONE; // RULE2
          end else begin
            count <= count + CNT_W'(1);
          end
        end
        TIMER_IDLE: begin
          state <= TIMER_IDLE;
        end
        TIMER_DONE: begin
          state <= TIMER_DONE;
        end
        default: begin
          state <= TIMER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      seen_refresh <= 1'b0;
    end else if (refresh_i) begin
      seen_refresh <= 1'b1; // RULE8
    end
  end

  assign readback_valid_o = (state == TIMER_DONE); // RULE2
  assign latched_valid_o = readback_valid_o && seen_refresh; // RULE8

  // ----------------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------------
  assign sense_range_ch1_o = active_range[SENSE_RANGE_CH1_LSB +: 2]; // RULE4
  assign sense_range_ch2_o = active_range[SENSE_RANGE_CH2_LSB +: 2]; // RULE4
  assign sense_range_ch3_o = active_range[SENSE_RANGE_CH3_LSB +: 2]; // RULE4
  assign sense_range_ch4_o = active_range[SENSE_RANGE_CH4_LSB +: 2]; // RULE4
  assign bus_range_ch1_o = active_range[BUS_RANGE_CH1_LSB +: 2]; // RULE6
  assign bus_range_ch2_o = active_range[BUS_RANGE_CH2_LSB +: 2]; // RULE6
  assign bus_range_ch3_o = active_range[BUS_RANGE_CH3_LSB +: 2]; // RULE6
  assign bus_range_ch4_o = active_range[BUS_RANGE_CH4_LSB +: 2]; // RULE6

  // Flags a reserved code in any sense or bus field.
  assign range_reserved_o[1] = // RULE3
    (sense_range_ch1_o == RANGE_RESERVED) ||
    (sense_range_ch2_o == RANGE_RESERVED) ||
    (sense_range_ch3_o == RANGE_RESERVED) ||
    (sense_range_ch4_o == RANGE_RESERVED);
  assign range_reserved_o[0] = // RULE5
    (bus_range_ch1_o == RANGE_RESERVED) ||
    (bus_range_ch2_o == RANGE_RESERVED) ||
    (bus_range_ch3_o == RANGE_RESERVED) ||
    (bus_range_ch4_o == RANGE_RESERVED);

  assign mode = latched_control[SAMPLE_MODE_LSB +: 4];
  assign pin2_function_select_o = latched_control[PIN2_FUNCTION_LSB +: 2];
  assign pin1_function_select_o = latched_control[PIN1_FUNCTION_LSB +: 2];
  assign channel_off_o = latched_control[CHANNEL_OFF_LSB +: 4];

  always_comb begin
    if (mode[3] == 1'b0) begin
      latched_mode_class_o = mode[2] ? SEL_CONTINUOUS
                                     : SEL_CONTINUOUS_ADAPTIVE; // RULE10
    end else begin
      case (mode)
        MODE_SINGLE_SHOT: latched_mode_class_o = SEL_SINGLE_SHOT; // RULE10
        MODE_SINGLE_SHOT_8X: latched_mode_class_o = SEL_SINGLE_SHOT_8X;
        MODE_FAST: latched_mode_class_o = SEL_FAST;
        MODE_BURST: latched_mode_class_o = SEL_BURST;
        MODE_SLEEP: latched_mode_class_o = SEL_SLEEP; // RULE10
        default: latched_mode_class_o = SEL_RESERVED;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  always_comb begin
    case (reg_addr_i)
      ACTIVE_RANGE_OFFSET: next_rdata = active_range;
      LATCHED_CONTROL_OFFSET: next_rdata = latched_control; // RULE9
      default: next_rdata = 16'h0000;
    endcase
  end

  assign reg_hit_o = (reg_addr_i == ACTIVE_RANGE_OFFSET) ||
                     (reg_addr_i == LATCHED_CONTROL_OFFSET);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule : active_latched_config_readback

// ---- rtl/capture_if.sv ----
/*
  Interface between the readback block and one capture register: load
  strobe, data to capture and the held image.
  Assumes the owner and the user run on the same clock.
*/
`timescale 1ns/1ps
interface capture_if #(
  parameter int WIDTH = 16
);
  logic load;
  logic [WIDTH-1:0] data;
  logic [WIDTH-1:0] image;

  modport owner (input load, input data, output image);
  modport user (output load, output data, input image);
endinterface : capture_if

// ---- rtl/capture_reg.sv ----
/*
  A capture register: takes the offered data on a load strobe and holds it.
  Assumes a synchronous active-low reset on the system clock.
*/
`timescale 1ns/1ps
module capture_reg #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  capture_if.owner cap
);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cap.image <= RESET_VALUE;
    end else if (cap.load) begin
      cap.image <= cap.data;
    end
  end

endmodule : capture_reg

// ---- rtl/readback_pkg.sv ----
/*
  Constants shared by the configuration readback block: register offsets,
  field positions, reset values, range and mode codes and the valid delay.
  Assumes a single 250 MHz system clock.
*/
package readback_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] STAGED_RANGE_OFFSET = 8'h1D;
  localparam logic [7:0] ACTIVE_CONTROL_OFFSET = 8'h21;
  localparam logic [7:0] ACTIVE_RANGE_OFFSET = 8'h22;
  localparam logic [7:0] LATCHED_CONTROL_OFFSET = 8'h23;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int SENSE_RANGE_CH1_LSB = 14;
  localparam int SENSE_RANGE_CH2_LSB = 12;
  localparam int SENSE_RANGE_CH3_LSB = 10;
  localparam int SENSE_RANGE_CH4_LSB = 8;
  localparam int BUS_RANGE_CH1_LSB = 6;
  localparam int BUS_RANGE_CH2_LSB = 4;
  localparam int BUS_RANGE_CH3_LSB = 2;
  localparam int BUS_RANGE_CH4_LSB = 0;
  localparam int SAMPLE_MODE_LSB = 12;
  localparam int PIN2_FUNCTION_LSB = 10;
  localparam int PIN1_FUNCTION_LSB = 8;
  localparam int CHANNEL_OFF_LSB = 4;

  // Implemented bits of the latched control image; bits 3-0 read as zero.
  localparam logic [15:0] LATCHED_CONTROL_MASK = 16'hFFF0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] ACTIVE_RANGE_RESET = 16'h0000;
  localparam logic [15:0] LATCHED_CONTROL_RESET = 16'h0700;

  // ----------------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RANGE_UNIPOLAR = 2'h0,
    RANGE_BIPOLAR_FULL = 2'h1,
    RANGE_BIPOLAR_HALF = 2'h2,
    RANGE_RESERVED = 2'h3
  } range_code_t;

  localparam logic [3:0] MODE_SINGLE_SHOT = 4'h8;
  localparam logic [3:0] MODE_SINGLE_SHOT_8X = 4'h9;
  localparam logic [3:0] MODE_FAST = 4'hA;
  localparam logic [3:0] MODE_BURST = 4'hB;
  localparam logic [3:0] MODE_SLEEP = 4'hF;

  typedef enum logic [2:0] {
    SEL_CONTINUOUS_ADAPTIVE,
    SEL_CONTINUOUS,
    SEL_SINGLE_SHOT,
    SEL_SINGLE_SHOT_8X,
    SEL_FAST,
    SEL_BURST,
    SEL_SLEEP,
    SEL_RESERVED
  } mode_class_t;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int VALID_DELAY_US = 1000;
  localparam int VALID_DELAY_CYCLES =
    VALID_DELAY_US * (1000000 / CLK_PERIOD_PS);

endpackage : readback_pkg
